// ### verilog/fbe_host.sv
// Host controller issuing bypass, erase and suspend sequences to a parallel NOR flash
module fbe_host #(
    parameter int WIN_CYC  = fbe_pkg::WIN_CYC,
    parameter int SUSP_CYC = fbe_pkg::SUSP_CYC
) (
    input  wire logic                          clk,
    input  wire logic                          srst,
    // User side
    input  wire logic                          req_valid,
    input  wire fbe_pkg::fbe_req_s             req,
    output logic                               req_ready,
    output logic                               resp_valid,
    output logic [fbe_pkg::DATA_W-1:0]         resp_data,
    output logic                               resp_err,
    output logic                               in_bypass,
    output logic                               erasing,
    output logic                               suspended,
    output logic                               window_open,
    // Flash pins
    output logic [fbe_pkg::ADDR_W-1:0]         flash_addr,
    output logic [fbe_pkg::DATA_W-1:0]         flash_dq_out,
    output logic                               flash_dq_oe,
    input  wire logic [fbe_pkg::DATA_W-1:0]    flash_dq_in,
    output logic                               flash_ce_n,
    output logic                               flash_we_n,
    output logic                               flash_oe_n,
    output logic                               flash_reset_n,
    input  wire logic                          ready_busy_n_pin
);
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_SEQ  = 3'b001,
        HS_WAIT = 3'b011,
        HS_DONE = 3'b010,
        HS_RST  = 3'b110
    } fbe_hs_e;

    fbe_hs_e              st;
    fbe_pkg::fbe_req_s    cur;
    logic [2:0]           idx;
    logic [2:0]           nseq;
    logic                 bc_busy;
    logic                 bc_done;
    logic                 bc_start;
    logic                 bc_read;
    logic [15:0]          bc_rdata;
    fbe_pkg::fbe_cycle_s  cyc;
    logic [2:0]           rb_sync;
    logic                 rb_ready;
    logic [31:0]          gap_cnt;
    logic [31:0]          sus_cnt;
    logic                 erase_kind;

    // Ready/busy pin synchroniser; change taken once stages two and three agree
    always_ff @(posedge clk) begin
        if (srst) begin
            rb_sync  <= 3'b111;
            rb_ready <= 1'b1;
        end else begin
            rb_sync <= {rb_sync[1:0], ready_busy_n_pin};
            if (rb_sync[1] == rb_sync[2]) begin
                rb_ready <= rb_sync[2];
            end
        end
    end

    // Legality of a request against current mode
    wire op_legal =
        in_bypass ? (req.op == fbe_pkg::OP_BYP_PROG  || req.op == fbe_pkg::OP_BYP_EXIT ||
                     req.op == fbe_pkg::OP_BYP_RESET)
      : suspended ? (req.op == fbe_pkg::OP_RESUME || req.op == fbe_pkg::OP_READ ||
                     req.op == fbe_pkg::OP_AUTOSEL || req.op == fbe_pkg::OP_RESET)
      : window_open ? (req.op == fbe_pkg::OP_SECT_ADD || req.op == fbe_pkg::OP_SUSPEND)
      : erasing ? (req.op == fbe_pkg::OP_SUSPEND && erase_kind)
      : (req.op != fbe_pkg::OP_BYP_PROG && req.op != fbe_pkg::OP_BYP_EXIT &&
         req.op != fbe_pkg::OP_BYP_RESET && req.op != fbe_pkg::OP_SECT_ADD &&
         req.op != fbe_pkg::OP_SUSPEND && req.op != fbe_pkg::OP_RESUME);

    // Cycle count per operation
    always_comb begin
        case (cur.op)
            fbe_pkg::OP_BYP_ENTER:  nseq = 3'd3;
            fbe_pkg::OP_BYP_PROG:   nseq = 3'd2;
            fbe_pkg::OP_BYP_EXIT:   nseq = 3'd2;
            fbe_pkg::OP_CHIP_ERASE: nseq = 3'd6;
            fbe_pkg::OP_SECT_ERASE: nseq = 3'd6;
            fbe_pkg::OP_AUTOSEL:    nseq = 3'd3;
            default:                nseq = 3'd1;
        endcase
    end

    // Address and data of cycle idx
    wire [19:0] sect_addr = {1'b0, cur.addr[fbe_pkg::SECT_HI:fbe_pkg::SECT_LO], 12'h000};
    always_comb begin
        cyc.addr = cur.addr;
        cyc.data = 16'h0000;
        if (cur.op == fbe_pkg::OP_BYP_PROG) begin
            cyc.data = (idx == 3'd0) ? {8'h00, fbe_pkg::CMD_PROG} : cur.data;
        end else if (cur.op == fbe_pkg::OP_BYP_EXIT) begin
            cyc.data = {8'h00, (idx == 3'd0) ? fbe_pkg::CMD_BYP_EXIT1 : fbe_pkg::CMD_BYP_EXIT2};
        end else if (cur.op == fbe_pkg::OP_BYP_RESET || cur.op == fbe_pkg::OP_RESET) begin
            cyc.data = {8'h00, fbe_pkg::CMD_RESET};
        end else if (cur.op == fbe_pkg::OP_SECT_ADD) begin
            cyc.addr = sect_addr;
            cyc.data = {8'h00, fbe_pkg::CMD_SECT_ERASE};
        end else if (cur.op == fbe_pkg::OP_SUSPEND) begin
            cyc.data = {8'h00, fbe_pkg::CMD_SUSPEND};
        end else if (cur.op == fbe_pkg::OP_RESUME) begin
            cyc.data = {8'h00, fbe_pkg::CMD_RESUME};
        end else if (cur.op == fbe_pkg::OP_READ) begin
            cyc.data = 16'h0000;
        end else if (idx == 3'd0 || idx == 3'd3) begin
            cyc.addr = fbe_pkg::ADDR_UNLOCK1;
            cyc.data = {8'h00, fbe_pkg::CMD_UNLOCK1};
        end else if (idx == 3'd1 || idx == 3'd4) begin
            cyc.addr = fbe_pkg::ADDR_UNLOCK2;
            cyc.data = {8'h00, fbe_pkg::CMD_UNLOCK2};
        end else if (idx == 3'd2) begin
            cyc.addr = fbe_pkg::ADDR_UNLOCK1;
            cyc.data = {8'h00, (cur.op == fbe_pkg::OP_BYP_ENTER) ? fbe_pkg::CMD_BYPASS :
                       (cur.op == fbe_pkg::OP_AUTOSEL) ? fbe_pkg::CMD_AUTOSEL :
                       fbe_pkg::CMD_ERASE_SETUP};
        end else if (cur.op == fbe_pkg::OP_CHIP_ERASE) begin
            cyc.addr = fbe_pkg::ADDR_UNLOCK1;
            cyc.data = {8'h00, fbe_pkg::CMD_CHIP_ERASE};
        end else begin
            cyc.addr = sect_addr;
            cyc.data = {8'h00, fbe_pkg::CMD_SECT_ERASE};
        end
    end

    assign bc_read = (cur.op == fbe_pkg::OP_READ);
    assign bc_start = (st == HS_SEQ) && !bc_busy && !bc_done;

    fbe_bus_cycle u_cycle (
        .clk     (clk),
        .srst    (srst),
        .start   (bc_start),
        .is_read (bc_read),
        .cyc     (cyc),
        .busy    (bc_busy),
        .done    (bc_done),
        .rdata   (bc_rdata),
        .addr    (flash_addr),
        .dq_out  (flash_dq_out),
        .dq_oe   (flash_dq_oe),
        .dq_in   (flash_dq_in),
        .ce_n    (flash_ce_n),
        .we_n    (flash_we_n),
        .oe_n    (flash_oe_n)
    );

    wire last_cyc = bc_done && (idx == nseq - 3'd1);
    // Our count lags the device timer by a write's latency; close early by twice that plus 8 cycles
    localparam int WIN_MARGIN = 2 * (fbe_pkg::WE_LO_CYC + fbe_pkg::WE_HI_CYC) + 8;
    wire win_exp  = (gap_cnt >= 32'(WIN_CYC - WIN_MARGIN) - 32'd1);

    always_ff @(posedge clk) begin
        if (srst) begin
            st            <= HS_RST;
            cur           <= '0;
            idx           <= 3'd0;
            req_ready     <= 1'b0;
            resp_valid    <= 1'b0;
            resp_data     <= '0;
            resp_err      <= 1'b0;
            in_bypass     <= 1'b0;
            erasing       <= 1'b0;
            suspended     <= 1'b0;
            window_open   <= 1'b0;
            erase_kind    <= 1'b0;
            gap_cnt       <= 32'd0;
            sus_cnt       <= 32'd0;
            flash_reset_n <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            resp_err   <= 1'b0;
            if (window_open) begin
                gap_cnt <= gap_cnt + 32'd1;
                if (win_exp) begin
                    window_open <= 1'b0;
                end
            end
            // Erase end seen on the pin returns both sides to array read
            if (erasing && !window_open && !suspended && rb_ready && sus_cnt == 32'd0
                && gap_cnt >= 32'(WIN_CYC) + 32'd8) begin
                erasing <= 1'b0;
            end else if (erasing && !window_open) begin
                gap_cnt <= gap_cnt + 32'd1;
            end
            if (sus_cnt != 32'd0) begin
                sus_cnt <= sus_cnt - 32'd1;
            end
            case (st)
                HS_RST: begin
                    flash_reset_n <= 1'b1;
                    req_ready     <= 1'b1;
                    st            <= HS_IDLE;
                end
                HS_IDLE: begin
                    if (req_valid && sus_cnt == 32'd0) begin
                        req_ready <= 1'b0;
                        if (op_legal) begin
                            cur <= req;
                            idx <= 3'd0;
                            st  <= HS_SEQ;
                        end else begin
                            resp_valid <= 1'b1;
                            resp_err   <= 1'b1;
                            st         <= HS_DONE;
                        end
                    end
                end
                HS_SEQ: begin
                    if (bc_done) begin
                        idx <= idx + 3'd1;
                        if (last_cyc) begin
                            st <= HS_WAIT;
                        end
                    end
                end
                HS_WAIT: begin
                    resp_valid <= 1'b1;
                    resp_data  <= bc_rdata;
                    st         <= HS_DONE;
                    case (cur.op)
                        fbe_pkg::OP_BYP_ENTER: in_bypass <= 1'b1;
                        fbe_pkg::OP_BYP_EXIT,
                        fbe_pkg::OP_BYP_RESET: in_bypass <= 1'b0;
                        fbe_pkg::OP_CHIP_ERASE: begin
                            erasing    <= 1'b1;
                            erase_kind <= 1'b0;
                            gap_cnt    <= 32'd0;
                        end
                        fbe_pkg::OP_SECT_ERASE, fbe_pkg::OP_SECT_ADD: begin
                            erasing     <= 1'b1;
                            erase_kind  <= 1'b1;
                            window_open <= 1'b1;
                            gap_cnt     <= 32'd0;
                        end
                        fbe_pkg::OP_SUSPEND: begin
                            window_open <= 1'b0;
                            suspended   <= 1'b1;
                            // Window suspend is immediate, active erase needs the latency
                            sus_cnt     <= window_open ? 32'd0 : 32'(SUSP_CYC);
                        end
                        fbe_pkg::OP_RESUME: begin
                            suspended <= 1'b0;
                            gap_cnt   <= 32'(WIN_CYC);
                        end
                        fbe_pkg::OP_RESET: if (!suspended) begin
                            erasing <= 1'b0;
                        end
                        default: ;
                    endcase
                end
                HS_DONE: begin
                    // Ready stays low until the suspend latency has run out
                    if (sus_cnt <= 32'd1) begin
                        req_ready <= 1'b1;
                        st        <= HS_IDLE;
                    end
                end
                default: st <= HS_IDLE;
            endcase
        end
    end

    // Checks
    property p_bypass_excl;
        @(posedge clk) disable iff (srst) in_bypass |-> !erasing;
    endproperty
    a_bypass_excl: assert property (p_bypass_excl)
        else $error("bypass and erase together");
    property p_bypass_enter;
        @(posedge clk) disable iff (srst)
        (st == HS_WAIT && cur.op == fbe_pkg::OP_BYP_ENTER) |=> in_bypass;
    endproperty
    a_bypass_enter: assert property (p_bypass_enter)
        else $error("bypass not entered");
    property p_no_suspend_chip;
        @(posedge clk) disable iff (srst)
        (st == HS_SEQ && cur.op == fbe_pkg::OP_SUSPEND) |-> erase_kind;
    endproperty
    a_no_suspend_chip: assert property (p_no_suspend_chip)
        else $error("suspend during chip erase");
    property p_window_bound;
        @(posedge clk) disable iff (srst)
        window_open |-> gap_cnt < 32'(WIN_CYC - WIN_MARGIN);
    endproperty
    a_window_bound: assert property (p_window_bound)
        else $error("window overran");
    property p_suspend_wait;
        @(posedge clk) disable iff (srst)
        sus_cnt != 32'd0 |-> !req_ready && !(st == HS_SEQ && $rose(st == HS_SEQ));
    endproperty
    a_suspend_wait: assert property (p_suspend_wait)
        else $error("command during suspend latency");
    property p_resume_clear;
        @(posedge clk) disable iff (srst)
        (st == HS_WAIT && cur.op == fbe_pkg::OP_RESUME) |=> !suspended;
    endproperty
    a_resume_clear: assert property (p_resume_clear)
        else $error("resume failed");
    property p_chip_six;
        @(posedge clk) disable iff (srst)
        (st == HS_SEQ && cur.op == fbe_pkg::OP_CHIP_ERASE && last_cyc) |-> idx == 3'd5;
    endproperty
    a_chip_six: assert property (p_chip_six)
        else $error("chip erase length");
    property p_sect_addr;
        @(posedge clk) disable iff (srst)
        (cur.op == fbe_pkg::OP_SECT_ADD) |->
            cyc.addr[11:0] == 12'h000 && cyc.data == {8'h00, fbe_pkg::CMD_SECT_ERASE};
    endproperty
    a_sect_addr: assert property (p_sect_addr)
        else $error("sector address bits");
    c_bypass: cover property (@(posedge clk) $rose(in_bypass));
    c_suspend: cover property (@(posedge clk) $rose(suspended));
    c_erase_end: cover property (@(posedge clk) $fell(erasing));
endmodule

// ### verilog/fbe_pkg.sv
// Package: command codes, bus widths, timing counts and carrier types for the flash host
package fbe_pkg;
    localparam int          ADDR_W          = 20;
    localparam int          DATA_W          = 16;
    // Command values
    localparam logic [7:0]  CMD_UNLOCK1     = 8'haa;
    localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
    localparam logic [7:0]  CMD_BYPASS      = 8'h20;
    localparam logic [7:0]  CMD_PROG        = 8'ha0;
    localparam logic [7:0]  CMD_BYP_EXIT1   = 8'h90;
    localparam logic [7:0]  CMD_BYP_EXIT2   = 8'h00;
    localparam logic [7:0]  CMD_RESET       = 8'hf0;
    localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
    localparam logic [7:0]  CMD_SECT_ERASE  = 8'h30;
    localparam logic [7:0]  CMD_SUSPEND     = 8'hb0;
    localparam logic [7:0]  CMD_RESUME      = 8'h30;
    localparam logic [7:0]  CMD_AUTOSEL     = 8'h90;
    // Unlock addresses (word mode)
    localparam logic [19:0] ADDR_UNLOCK1    = 20'h00555;
    localparam logic [19:0] ADDR_UNLOCK2    = 20'h002aa;
    // Sector select field
    localparam int          SECT_HI         = 18;
    localparam int          SECT_LO         = 12;
    // Status bit positions
    localparam int          BIT_POLL        = 7;
    localparam int          BIT_TOGGLE      = 6;
    localparam int          BIT_WINDOW      = 3;
    localparam int          BIT_ETOGGLE     = 2;
    // Timing
    localparam int          CLK_MHZ         = 50;
    localparam int          WIN_US          = 50;
    localparam int          SUSP_US         = 35;
    localparam int          CLK_NS          = 1000 / CLK_MHZ;
    // Gap between additional sector writes: must stay under the window, so round down
    localparam int          WIN_CYC         = WIN_US * CLK_MHZ;
    // Worst case suspend latency
    localparam int          SUSP_CYC        = SUSP_US * CLK_MHZ;
    // Write pulse: low and high phases
    localparam int          WE_LO_NS        = 40;
    localparam int          WE_HI_NS        = 40;
    localparam int          WE_LO_CYC       = (WE_LO_NS + CLK_NS - 1) / CLK_NS;
    localparam int          WE_HI_CYC       = (WE_HI_NS + CLK_NS - 1) / CLK_NS;
    localparam int          RD_NS           = 80;
    localparam int          RD_CYC          = (RD_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [3:0] {
        OP_BYP_ENTER  = 4'h0,
        OP_BYP_PROG   = 4'h1,
        OP_BYP_EXIT   = 4'h2,
        OP_BYP_RESET  = 4'h3,
        OP_CHIP_ERASE = 4'h4,
        OP_SECT_ERASE = 4'h5,
        OP_SECT_ADD   = 4'h6,
        OP_SUSPEND    = 4'h7,
        OP_RESUME     = 4'h8,
        OP_AUTOSEL    = 4'h9,
        OP_RESET      = 4'ha,
        OP_READ       = 4'hb
    } fbe_op_e;

    typedef struct packed {
        fbe_op_e             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } fbe_req_s;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } fbe_cycle_s;
endpackage

// ### verilog/fbe_bus_cycle.sv
// Single asynchronous bus cycle engine: one write pulse or one read on the flash pins
module fbe_bus_cycle #(
    parameter int LO_CYC = fbe_pkg::WE_LO_CYC,
    parameter int HI_CYC = fbe_pkg::WE_HI_CYC,
    parameter int RD_CYC = fbe_pkg::RD_CYC
) (
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic                          start,
    input  wire logic                          is_read,
    input  wire fbe_pkg::fbe_cycle_s           cyc,
    output logic                               busy,
    output logic                               done,
    output logic [fbe_pkg::DATA_W-1:0]         rdata,
    output logic [fbe_pkg::ADDR_W-1:0]         addr,
    output logic [fbe_pkg::DATA_W-1:0]         dq_out,
    output logic                               dq_oe,
    input  wire logic [fbe_pkg::DATA_W-1:0]    dq_in,
    output logic                               ce_n,
    output logic                               we_n,
    output logic                               oe_n
);
    typedef enum logic [1:0] {
        BC_IDLE = 2'b00,
        BC_LOW  = 2'b01,
        BC_HIGH = 2'b11
    } fbe_bc_e;

    fbe_bc_e     st;
    logic [7:0]  cnt;
    logic        last;

    assign last = (cnt == 8'h01);

    always_ff @(posedge clk) begin
        if (srst) begin
            st     <= BC_IDLE;
            cnt    <= 8'h00;
            busy   <= 1'b0;
            done   <= 1'b0;
            rdata  <= '0;
            addr   <= '0;
            dq_out <= '0;
            dq_oe  <= 1'b0;
            ce_n   <= 1'b1;
            we_n   <= 1'b1;
            oe_n   <= 1'b1;
        end else begin
            done <= 1'b0;
            case (st)
                BC_IDLE: begin
                    if (start) begin
                        st     <= BC_LOW;
                        busy   <= 1'b1;
                        addr   <= cyc.addr;
                        dq_out <= cyc.data;
                        dq_oe  <= !is_read;
                        ce_n   <= 1'b0;
                        we_n   <= is_read;
                        oe_n   <= !is_read;
                        cnt    <= is_read ? 8'(RD_CYC) : 8'(LO_CYC);
                    end
                end
                BC_LOW: begin
                    if (last) begin
                        // Data latched by the device on this rising edge
                        st    <= BC_HIGH;
                        we_n  <= 1'b1;
                        oe_n  <= 1'b1;
                        ce_n  <= 1'b1;
                        rdata <= dq_in;
                        cnt   <= 8'(HI_CYC);
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                BC_HIGH: begin
                    // Hold data a little past the edge before releasing the bus
                    dq_oe <= 1'b0;
                    if (last) begin
                        st   <= BC_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: st <= BC_IDLE;
            endcase
        end
    end
endmodule

// ### tb/fbe_flash_model.sv
// Behavioural flash device: command decoder, erase timers and status reads
module fbe_flash_model #(
    parameter int WIN = 40,
    parameter int ERS = 300
) (
    input  wire logic        clk,
    input  wire logic [19:0] flash_addr,
    input  wire logic [15:0] flash_dq_out,
    input  wire logic        flash_dq_oe,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_we_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_reset_n,
    output logic      [15:0] flash_dq_in,
    output logic             ready_busy_n_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [39:0]  hist;
    logic [127:0] sel;
    logic [15:0]  last;
    logic         wa_q, byp, prog, chip, win, ers, susp;
    int           t, progs;
    // Write ends when either enable rises; host may lift both at once
    wire          wact = !flash_we_n && !flash_ce_n && flash_dq_oe;
    wire          wr = wa_q && !wact;
    wire [7:0]    d = flash_dq_out[7:0];
    wire          rd = !flash_oe_n && !flash_ce_n;
    wire          ext = d == 8'hf0 || hist[7:0] == 8'h90 && d == 8'h00;
    // Suspended sectors answer with status, polling bit high
    wire [15:0]   q = (susp && sel[flash_addr[18:12]]) ? 16'h0080 : 16'h00a5;
    assign ready_busy_n_pin = !(chip || win || (ers && !susp));
    // Released bus shows the inverse of its last value, never a stale copy
    assign flash_dq_in = rd ? q : ~last;
    always @(posedge clk) begin
        wa_q <= wact;
        if (rd) last <= q;
        if (!flash_reset_n) begin
            {byp, prog, chip, win, ers, susp} <= '0;
            {sel, hist} <= '0;
            t <= 0;
            progs <= 0;
        end else begin
            if (!ready_busy_n_pin) t <= t + 1;
            if (win && t >= WIN) begin
                {win, ers} <= 2'b01;
                t <= 0;
            end
            if ((chip || ers && !susp) && t >= ERS) begin
                {chip, ers, sel} <= '0;
            end
            if (wr) begin
                hist <= {hist[31:0], d};
                if (chip) hist <= hist;
                else if (susp) susp <= d != 8'h30;
                else if (win || ers) begin
                    if (d == 8'hb0) {win, ers, susp} <= 3'b011;
                    else if (win && d == 8'h30) begin
                        sel[flash_addr[18:12]] <= 1'b1;
                        t <= 0;
                    end else if (win) {win, sel} <= '0;
                end else if (byp) begin
                    progs <= progs + int'(prog);
                    prog <= !prog && d == 8'ha0;
                    if (!prog && ext) byp <= 1'b0;
                end else if (hist[15:0] == 16'haa55 && d == 8'h20) byp <= 1'b1;
                else if (hist == 40'haa5580aa55) begin
                    chip <= d == 8'h10;
                    win <= d == 8'h30;
                    t <= 0;
                    if (d == 8'h30) sel[flash_addr[18:12]] <= 1'b1;
                end
            end
        end
    end
endmodule

// ### tb/fbe_host_test.sv
// Self-checking bench for the flash host: bypass, chip erase, sector erase, suspend
module fbe_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk, srst, req_valid, req_ready, resp_valid, resp_err;
    logic              in_bypass, erasing, suspended, window_open, ready_busy_n_pin;
    logic              flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n;
    logic [15:0]       resp_data, flash_dq_out, flash_dq_in;
    logic [19:0]       flash_addr;
    fbe_pkg::fbe_req_s req;
    int                err_count, samples_checked, cycles, n;
    // Short window and suspend counts keep the run brief
    fbe_host #(.WIN_CYC(40), .SUSP_CYC(20)) DUT (.clk, .srst, .req_valid, .req, .req_ready,
        .resp_valid, .resp_data, .resp_err, .in_bypass, .erasing, .suspended, .window_open,
        .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_we_n,
        .flash_oe_n, .flash_reset_n, .ready_busy_n_pin);
    fbe_flash_model #(.WIN(40), .ERS(300)) FM (.clk, .flash_addr, .flash_dq_out, .flash_dq_oe,
        .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n, .flash_dq_in, .ready_busy_n_pin);
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task automatic final_report();
        $display("Checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask
    // Request held until taken; the answer is a one-cycle pulse
    task automatic op(input fbe_pkg::fbe_op_e o, input logic [19:0] a, input logic err);
        int k;
        req_valid <= 1'b1;
        req <= {o, a, a[15:0]};
        k = 0;
        do @(posedge clk); while (req_ready !== 1'b1 && k++ < 100);
        req_valid <= 1'b0;
        k = 0;
        do @(posedge clk); while (resp_valid !== 1'b1 && k++ < 300);
        check(resp_valid === 1'b1 && resp_err === err, "response or error flag");
        @(posedge clk);
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (erasing !== 1'b0 && k++ < 3000) @(posedge clk);
    endtask
    initial begin
        {srst, req_valid, req, cycles, err_count, samples_checked} = {1'b1, 1'b0, 40'h0, 96'h0};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        op(fbe_pkg::OP_BYP_ENTER, 20'h0, 1'b0);
        check(in_bypass === 1'b1 && FM.byp === 1'b1, "bypass entry");
        op(fbe_pkg::OP_BYP_PROG, 20'h01234, 1'b0);
        check(FM.progs === 1, "bypass program");
        op(fbe_pkg::OP_CHIP_ERASE, 20'h0, 1'b1);
        check(FM.chip === 1'b0 && FM.byp === 1'b1, "refused in bypass");
        op(fbe_pkg::OP_BYP_EXIT, 20'h0, 1'b0);
        check(in_bypass === 1'b0 && FM.byp === 1'b0, "bypass exit");
        op(fbe_pkg::OP_BYP_ENTER, 20'h0, 1'b0);
        op(fbe_pkg::OP_BYP_RESET, 20'h0, 1'b0);
        check(in_bypass === 1'b0 && FM.byp === 1'b0, "bypass reset");
        $display("Bypass test done");
        op(fbe_pkg::OP_CHIP_ERASE, 20'h0, 1'b0);
        check(erasing === 1'b1 && FM.chip === 1'b1, "chip erase start");
        op(fbe_pkg::OP_SUSPEND, 20'h0, 1'b1);
        check(FM.susp === 1'b0, "suspend in chip erase");
        wait_idle();
        check(erasing === 1'b0 && FM.chip === 1'b0, "chip erase end");
        $display("Chip erase test done");
        op(fbe_pkg::OP_SECT_ERASE, 20'h03000, 1'b0);
        op(fbe_pkg::OP_SECT_ADD, 20'h7f000, 1'b0);
        check(window_open === 1'b1 && FM.sel[3] === 1'b1 && FM.sel[127] === 1'b1, "sectors");
        op(fbe_pkg::OP_SUSPEND, 20'h0, 1'b0);
        n = 0;
        while (suspended !== 1'b1 && n++ < 100) @(posedge clk);
        check(FM.susp === 1'b1 && FM.win === 1'b0, "suspend in window");
        op(fbe_pkg::OP_READ, 20'h03000, 1'b0);
        check(resp_data === 16'h0080, "status from suspended sector");
        op(fbe_pkg::OP_READ, 20'h10000, 1'b0);
        check(resp_data === 16'h00a5, "array data elsewhere");
        op(fbe_pkg::OP_AUTOSEL, 20'h0, 1'b0);
        op(fbe_pkg::OP_RESET, 20'h0, 1'b0);
        check(suspended === 1'b1 && FM.susp === 1'b1, "back to suspend");
        op(fbe_pkg::OP_RESUME, 20'h0, 1'b0);
        check(suspended === 1'b0 && FM.susp === 1'b0, "resume");
        op(fbe_pkg::OP_SUSPEND, 20'h0, 1'b0);
        check(suspended === 1'b1 && FM.susp === 1'b1 && FM.ers === 1'b1, "suspend erasing");
        op(fbe_pkg::OP_RESUME, 20'h0, 1'b0);
        check(suspended === 1'b0 && FM.susp === 1'b0, "second resume");
        op(fbe_pkg::OP_RESUME, 20'h0, 1'b1);
        wait_idle();
        check(erasing === 1'b0 && FM.sel === 128'h0, "sector erase end");
        $display("Sector erase test done");
        op(fbe_pkg::OP_SECT_ERASE, 20'h05000, 1'b0);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        check(erasing === 1'b0 && FM.win === 1'b0 && FM.ers === 1'b0, "reset abort");
        $display("Reset test done");
        final_report();
    end
endmodule
